// ===== common/tcc_pkg.sv
// Constants, field layout and mode codes of the timer capture/compare control block
package tcc_pkg;
	localparam int TCC_ADDR_W = 8;
	// Register byte addresses
	localparam logic [7:0] TCC_OFS_TMC = 8'h00;
	localparam logic [7:0] TCC_OFS_CRC = 8'h04;
	localparam logic [7:0] TCC_OFS_TOC = 8'h08;
	localparam logic [7:0] TCC_OFS_PRM = 8'h0c;
	localparam logic [7:0] TCC_OFS_CNT = 8'h10;
	localparam logic [7:0] TCC_OFS_CR0 = 8'h14;
	localparam logic [7:0] TCC_OFS_CR1 = 8'h18;
	// Reset values
	localparam logic [7:0] TCC_RST_8 = 8'h00;
	localparam logic [15:0] TCC_RST_16 = 16'h0000;
	// Timer mode control fields
	localparam int TCC_TMC_OVF = 0;
	localparam int TCC_TMC_OUTSEL = 1;
	localparam int TCC_TMC_MODE = 2;
	localparam logic [7:0] TCC_TMC_MASK = 8'h0f;
	// Capture/compare control fields
	localparam int TCC_CRC_CMP0 = 0;
	localparam int TCC_CRC_TRIG = 1;
	localparam int TCC_CRC_CMP1 = 2;
	localparam logic [7:0] TCC_CRC_MASK = 8'h07;
	// Output control fields
	localparam int TCC_TOC_OE = 0;
	localparam int TCC_TOC_INV0 = 1;
	localparam int TCC_TOC_RSTREQ = 2;
	localparam int TCC_TOC_SETREQ = 3;
	localparam int TCC_TOC_INV1 = 4;
	localparam int TCC_TOC_OSE = 5;
	localparam int TCC_TOC_OST = 6;
	// Prescaler mode fields
	localparam int TCC_PRM_CLK = 0;
	localparam int TCC_PRM_ES0 = 4;
	localparam int TCC_PRM_ES1 = 6;
	localparam logic [7:0] TCC_PRM_MASK = 8'hf3;
	// Edge select codes
	localparam logic [1:0] TCC_ES_FALL = 2'b00;
	localparam logic [1:0] TCC_ES_RISE = 2'b01;
	localparam logic [1:0] TCC_ES_BAD = 2'b10;
	localparam logic [1:0] TCC_ES_BOTH = 2'b11;
	localparam logic [15:0] TCC_CNT_MAX = 16'hffff;
	localparam int TCC_DIV_W = 9;
	typedef enum logic [1:0] {
		TCC_MODE_STOP = 2'b00,
		TCC_MODE_FREE = 2'b01,
		TCC_MODE_CLR_EDGE = 2'b10,
		TCC_MODE_CLR_MATCH = 2'b11
	} tcc_mode_t;
endpackage

// ===== core/tcc_edge_detect.sv
// Valid edge detector for one timer input pin
module tcc_edge_detect
	import tcc_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pin and selection
	input wire logic pin,
	input wire logic [1:0] edge_select,
	input wire logic enable,
	// Edge pulses
	output logic valid_edge,
	output logic rise,
	output logic fall
);
	typedef struct packed {
		logic prev;
		logic seen_run;
	} tcc_ed_state_t;
	tcc_ed_state_t s, next_s;

	// Until the first enable the history stays low, so a high pin reads as a rise
	always_comb
	begin
		next_s = s;
		if (enable)
			next_s.seen_run = 1'b1;
		if (enable || s.seen_run)
			next_s.prev = pin;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign rise = enable & pin & ~s.prev;
	assign fall = enable & ~pin & s.prev;

	always_comb
	begin
		case (edge_select)
			TCC_ES_FALL: valid_edge = fall;
			TCC_ES_RISE: valid_edge = rise;
			TCC_ES_BOTH: valid_edge = rise | fall;
			default: valid_edge = 1'b0;
		endcase
	end
endmodule

// ===== core/tcc_prescaler.sv
// Count clock prescaler with per-instance divisor table
module tcc_prescaler
	import tcc_pkg::*;
#(
	parameter int INST = 0
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Selection
	input wire logic [1:0] clock_select,
	input wire logic input0_edge,
	// Count enable pulse
	output logic count_tick
);
	typedef struct packed {
		logic [TCC_DIV_W-1:0] div;
	} tcc_ps_state_t;
	tcc_ps_state_t s, next_s;

	// Returns log2 of the divisor; bit 4 marks the external edge source
	function automatic logic [4:0] tcc_div_code(input int inst, input logic [1:0] code);
		logic [4:0] r;
		r = {1'b1, 4'd0};
		case (inst)
			1: case (code)
				2'b00: r = 5'd0; // Prohibited undivided clock still counts
				2'b01: r = 5'd2;
				default: r = {1'b1, 4'd0};
			endcase
			3: case (code)
				2'b00: r = 5'd2;
				2'b01: r = 5'd4;
				2'b10: r = 5'd9;
				default: r = {1'b1, 4'd0};
			endcase
			5: case (code)
				2'b00: r = 5'd0;
				2'b01: r = 5'd2;
				2'b10: r = 5'd8;
				default: r = {1'b1, 4'd0};
			endcase
			default: case (code)
				2'b00: r = 5'd1;
				2'b01: r = 5'd2;
				2'b10: r = 5'd3;
				default: r = {1'b1, 4'd0};
			endcase
		endcase
		return r;
	endfunction

	logic [4:0] sel;
	logic [TCC_DIV_W-1:0] mask;

	always_comb
	begin
		next_s.div = s.div + 1'b1;
		sel = tcc_div_code(INST, clock_select);
		mask = TCC_DIV_W'((1 << sel[3:0]) - 1);
		if (sel[4])
			count_tick = input0_edge;
		else
			count_tick = (s.div & mask) == mask;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s <= '0;
		else
			s <= next_s;
	end
endmodule

// ===== core/tcc_top.sv
// Timer capture/compare control with APB register access, one timer instance
module tcc_top
	import tcc_pkg::*;
#(
	parameter int INST = 0
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tcc_pkg::TCC_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Timer pins
	input wire logic timer_input0,
	input wire logic timer_input1,
	output logic timer_output_pin
);
	import tcc_pkg::*;

	localparam bit HAS_ONESHOT = !(INST == 2 || INST == 3);
	localparam bit EDGE_ONESHOT = (INST >= 4);

	typedef struct packed {
		logic [3:0] timer_mode_control;
		logic [2:0] capture_compare_control;
		logic [7:0] timer_output_control;
		logic [7:0] prescaler_mode;
		logic [15:0] timer_counter;
		logic [15:0] capture_compare_reg0;
		logic [15:0] capture_compare_reg1;
		logic output_flipflop;
		logic oneshot_armed;
		logic pin;
		logic [31:0] rdata;
	} tcc_state_t;
	tcc_state_t s, next_s;

	// Address decode for the error answer; the read mux decodes the offsets itself
	function automatic logic tcc_mapped(input logic [TCC_ADDR_W-1:0] a);
		case (a)
			TCC_OFS_TMC, TCC_OFS_CRC, TCC_OFS_TOC, TCC_OFS_PRM,
			TCC_OFS_CNT, TCC_OFS_CR0, TCC_OFS_CR1: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	logic running;
	tcc_mode_t mode;
	logic tick;
	logic ti0_valid, ti0_rise, ti0_fall;
	logic ti1_valid;
	logic ti0_inverse;
	logic cap0_trig;
	logic match0, match1;
	logic overflow_event;
	logic wr_access;
	logic wr_tmc, wr_crc, wr_toc, wr_prm, wr_cr0, wr_cr1;
	logic soft_trigger;
	logic oneshot_trigger;
	logic toggle;
	logic oneshot_mode;

	assign mode = tcc_mode_t'(s.timer_mode_control[TCC_TMC_MODE +: 2]);
	assign running = mode != TCC_MODE_STOP;

	tcc_edge_detect u_edge0 (
		.pclk(pclk),
		.presetn(presetn),
		.pin(timer_input0),
		.edge_select(s.prescaler_mode[TCC_PRM_ES0 +: 2]),
		.enable(running),
		.valid_edge(ti0_valid),
		.rise(ti0_rise),
		.fall(ti0_fall)
	);

	tcc_edge_detect u_edge1 (
		.pclk(pclk),
		.presetn(presetn),
		.pin(timer_input1),
		.edge_select(s.prescaler_mode[TCC_PRM_ES1 +: 2]),
		.enable(running),
		.valid_edge(ti1_valid),
		.rise(),
		.fall()
	);

	tcc_prescaler #(
		.INST(INST)
	) u_presc (
		.pclk(pclk),
		.presetn(presetn),
		.clock_select(s.prescaler_mode[TCC_PRM_CLK +: 2]),
		.input0_edge(ti0_valid),
		.count_tick(tick)
	);

	// Zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~tcc_mapped(paddr);
	assign prdata = s.rdata;
	assign timer_output_pin = s.pin;

	always_comb
	begin
		wr_access = psel & penable & pwrite;
		wr_tmc = wr_access & (paddr == TCC_OFS_TMC);
		wr_crc = wr_access & (paddr == TCC_OFS_CRC);
		wr_toc = wr_access & (paddr == TCC_OFS_TOC);
		wr_prm = wr_access & (paddr == TCC_OFS_PRM);
		wr_cr0 = wr_access & (paddr == TCC_OFS_CR0);
		wr_cr1 = wr_access & (paddr == TCC_OFS_CR1);
	end

	// Capture source for register 0: inverse phase of input 0 valid edge when TRIG is set, else input 1 valid edge
	always_comb
	begin
		case (s.prescaler_mode[TCC_PRM_ES0 +: 2])
			TCC_ES_FALL: ti0_inverse = ti0_rise;
			TCC_ES_RISE: ti0_inverse = ti0_fall;
			default: ti0_inverse = 1'b0; // Both edges: no capture
		endcase
		if (s.capture_compare_control[TCC_CRC_TRIG])
			cap0_trig = ti0_inverse;
		else
			cap0_trig = ti1_valid;
	end

	// Compare matches count only in compare mode and on a count clock
	always_comb
	begin
		match0 = running & tick & ~s.capture_compare_control[TCC_CRC_CMP0]
			& (s.timer_counter == s.capture_compare_reg0);
		match1 = running & tick & ~s.capture_compare_control[TCC_CRC_CMP1]
			& (s.timer_counter == s.capture_compare_reg1);
	end

	// Wrap detection; in clear-on-match mode only a top value of FFFFH wraps
	always_comb
	begin
		overflow_event = 1'b0;
		if (running && tick && s.timer_counter == TCC_CNT_MAX)
		begin
			if (mode == TCC_MODE_CLR_MATCH)
				overflow_event = s.capture_compare_reg0 == TCC_CNT_MAX;
			else
				overflow_event = 1'b1;
		end
	end

	always_comb
	begin
		oneshot_mode = HAS_ONESHOT & s.timer_output_control[TCC_TOC_OSE];
		soft_trigger = HAS_ONESHOT & wr_toc & pwdata[TCC_TOC_OST];
		oneshot_trigger = oneshot_mode & running
			& (soft_trigger | (EDGE_ONESHOT & ti0_valid));
		// Successive mode toggles freely; one-shot only while armed
		toggle = (s.timer_output_control[TCC_TOC_INV0] & match0)
			^ (s.timer_output_control[TCC_TOC_INV1] & match1);
		if (oneshot_mode && !s.oneshot_armed)
			toggle = 1'b0;
	end

	always_comb
	begin
		next_s = s;

		// Register writes
		if (wr_tmc)
			next_s.timer_mode_control = pwdata[3:0] & TCC_TMC_MASK[3:0];
		if (wr_crc)
			next_s.capture_compare_control = pwdata[2:0] & TCC_CRC_MASK[2:0];
		if (wr_toc)
		begin
			next_s.timer_output_control = 8'h00;
			next_s.timer_output_control[TCC_TOC_OE] = pwdata[TCC_TOC_OE];
			next_s.timer_output_control[TCC_TOC_INV0] = pwdata[TCC_TOC_INV0];
			next_s.timer_output_control[TCC_TOC_INV1] = pwdata[TCC_TOC_INV1];
			next_s.timer_output_control[TCC_TOC_OSE] =
				HAS_ONESHOT & pwdata[TCC_TOC_OSE];
		end
		if (wr_prm)
			next_s.prescaler_mode = pwdata[7:0] & TCC_PRM_MASK;
		if (wr_cr0)
			next_s.capture_compare_reg0 = pwdata[15:0];
		if (wr_cr1)
			next_s.capture_compare_reg1 = pwdata[15:0];

		// Counter
		if (!running)
			next_s.timer_counter = TCC_RST_16;
		else if (mode == TCC_MODE_CLR_EDGE && ti0_valid)
			next_s.timer_counter = TCC_RST_16;
		else if (oneshot_trigger)
			next_s.timer_counter = TCC_RST_16;
		else if (tick)
		begin
			if (mode == TCC_MODE_CLR_MATCH && match0)
				next_s.timer_counter = TCC_RST_16;
			else
				next_s.timer_counter = s.timer_counter + 16'h0001;
		end

		// Hardware set wins over a software clear in the same cycle
		if (overflow_event)
			next_s.timer_mode_control[TCC_TMC_OVF] = 1'b1;

		// Captures win over a bus write in the same cycle
		if (running && s.capture_compare_control[TCC_CRC_CMP0] && cap0_trig)
			next_s.capture_compare_reg0 = s.timer_counter;
		if (running && s.capture_compare_control[TCC_CRC_CMP1] && ti0_valid)
			next_s.capture_compare_reg1 = s.timer_counter;

		// One-shot arming: a trigger starts one pulse, compare 0 ends it
		if (!oneshot_mode || !running)
			next_s.oneshot_armed = 1'b0;
		else if (oneshot_trigger)
			next_s.oneshot_armed = 1'b1;
		else if (match0)
			next_s.oneshot_armed = 1'b0;

		// Output flip-flop; software forcing overrides a match toggle
		if (toggle)
			next_s.output_flipflop = ~s.output_flipflop;
		if (wr_toc)
		begin
			case ({pwdata[TCC_TOC_SETREQ], pwdata[TCC_TOC_RSTREQ]})
				2'b10: next_s.output_flipflop = 1'b1;
				2'b01: next_s.output_flipflop = 1'b0;
				default: ; // Both set is prohibited: left unchanged
			endcase
		end

		// Disabled output sits low
		next_s.pin = s.timer_output_control[TCC_TOC_OE] & s.output_flipflop;

		// Read data sampled in the setup cycle, presented in the access cycle
		if (psel && !penable && !pwrite)
		begin
			case (paddr)
				TCC_OFS_TMC: next_s.rdata = {28'h0000000, s.timer_mode_control};
				TCC_OFS_CRC: next_s.rdata = {29'h00000000, s.capture_compare_control};
				TCC_OFS_TOC: next_s.rdata = {24'h000000, s.timer_output_control};
				TCC_OFS_PRM: next_s.rdata = {24'h000000, s.prescaler_mode};
				TCC_OFS_CNT: next_s.rdata = {16'h0000, s.timer_counter};
				TCC_OFS_CR0: next_s.rdata = {16'h0000, s.capture_compare_reg0};
				TCC_OFS_CR1: next_s.rdata = {16'h0000, s.capture_compare_reg1};
				default: next_s.rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s <= '0;
			s.capture_compare_control <= TCC_RST_8[2:0];
			s.timer_output_control <= TCC_RST_8;
			s.prescaler_mode <= TCC_RST_8;
		end
		else
			s <= next_s;
	end
endmodule

// ===== testbench/tcc_top_sva.sv
// Checker for the APB answers and the output pin of the timer block
module tcc_top_sva
#(
	parameter int INST = 0
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tcc_pkg::TCC_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins
	input wire logic timer_input0,
	input wire logic timer_input1,
	input wire logic timer_output_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	import tcc_pkg::*;
	logic acc;
	logic rd;
	logic mapped;
	logic stopped;
	assign acc = psel && penable;
	assign rd = acc && !pwrite;
	assign mapped = paddr inside {TCC_OFS_TMC, TCC_OFS_CRC, TCC_OFS_TOC, TCC_OFS_PRM,
		TCC_OFS_CNT, TCC_OFS_CR0, TCC_OFS_CR1};
	// Known stopped until software writes a non-zero mode
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			stopped <= 1'b1;
		else if (acc && pwrite && paddr == TCC_OFS_TMC)
			stopped <= pwdata[3:2] == 2'b00;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence toc_wr(logic [4:0] low);
		acc && pwrite && paddr == TCC_OFS_TOC && pwdata[4:0] == low;
	endsequence
	chk_err_unmapped: assert property (acc && !mapped |-> pslverr ##1 !pslverr)
		else $error("unmapped access without error");
	chk_err_quiet: assert property (!acc || mapped |-> !pslverr)
		else $error("error outside unmapped access");
	chk_rd_unmapped: assert property (rd && !mapped |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	chk_upper_zero: assert property (rd && mapped |-> prdata[31:16] == 16'h0)
		else $error("upper read bits not zero");
	chk_crc_fields: assert property (rd && paddr == TCC_OFS_CRC |-> prdata[31:3] == 0)
		else $error("capture control spare bits set");
	chk_toc_fields: assert property (rd && paddr == TCC_OFS_TOC
		|-> prdata[31:6] == 0 && prdata[3:2] == 2'b00)
		else $error("output control request bits read back");
	chk_prm_fields: assert property (rd && paddr == TCC_OFS_PRM
		|-> prdata[31:8] == 0 && prdata[3:2] == 2'b00)
		else $error("prescaler spare bits set");
	chk_ff_set: assert property (toc_wr(5'b01001) |-> ##[1:3] timer_output_pin)
		else $error("set request did not raise pin");
	chk_ff_clear: assert property (toc_wr(5'b00101) |-> ##[1:3] !timer_output_pin)
		else $error("reset request did not lower pin");
	chk_oe_off: assert property (acc && pwrite && paddr == TCC_OFS_TOC && !pwdata[0]
		|-> ##2 !timer_output_pin)
		else $error("disabled output not low");
	chk_stop_zero: assert property (rd && paddr == TCC_OFS_CNT && stopped
		|-> prdata == 32'h0)
		else $error("stopped counter not zero");
endmodule

// ===== testbench/tcc_pin_model.sv
// Far-side pins: drives both timer inputs and counts output pin changes
module tcc_pin_model
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Levels asked by the bench
	input wire logic lvl0,
	input wire logic lvl1,
	// Pins
	input wire logic pin_out,
	output logic in0,
	output logic in1,
	output int toggles
);
	timeunit 1ns;
	timeprecision 1ns;
	logic last;
	// Pins move at clock edges only; the block samples them synchronously
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			in0 <= 1'b0;
			in1 <= 1'b0;
			last <= 1'b0;
			toggles <= 0;
		end
		else
		begin
			in0 <= lvl0;
			in1 <= lvl1;
			last <= pin_out;
			if (last !== pin_out)
				toggles <= toggles + 1;
		end
endmodule

// ===== testbench/timer_capture_compare_control_tb.sv
// Self-checking bench for the timer capture/compare control block
module timer_capture_compare_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import tcc_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [TCC_ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic timer_input0;
	logic timer_input1;
	logic timer_output_pin;
	logic lvl0 = 1'b0;
	logic lvl1 = 1'b0;
	logic last_err;
	int toggles;
	int error_cnt = 0;
	int n_compared = 0;

	always #25 pclk = ~pclk;

	tcc_top #(.INST(0)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .timer_input0, .timer_input1, .timer_output_pin);
	tcc_pin_model pins (.pclk, .presetn, .lvl0, .lvl1, .pin_out(timer_output_pin),
		.in0(timer_input0), .in1(timer_input1), .toggles);

	task automatic end_of_test;
		$display("Compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		psel <= 1'b1;
		pwrite <= wr_en;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		q = prdata;
		last_err = pslverr;
		if (pready !== 1'b1)
		begin
			error_cnt++;
			end_of_test;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		apb(1'b0, a, 32'h0, q);
		check(q, exp);
	endtask

	task automatic nz(input logic [7:0] a);
		logic [31:0] q;
		apb(1'b0, a, 32'h0, q);
		check({31'h0, q != 32'h0}, 32'h1);
	endtask

	task automatic t_reset_vals;
		logic [7:0] ofs[7] = '{TCC_OFS_TMC, TCC_OFS_CRC, TCC_OFS_TOC, TCC_OFS_PRM,
			TCC_OFS_CNT, TCC_OFS_CR0, TCC_OFS_CR1};
		foreach (ofs[i]) rd(ofs[i], 32'h0);
	endtask

	task automatic t_regs;
		logic [31:0] q;
		wr(TCC_OFS_CRC, 32'hff);
		rd(TCC_OFS_CRC, 32'h07);
		wr(TCC_OFS_PRM, 32'hff);
		rd(TCC_OFS_PRM, 32'hf3);
		wr(TCC_OFS_TOC, 32'h73);
		rd(TCC_OFS_TOC, 32'h33);
		wr(TCC_OFS_TOC, 32'h0);
		wr(TCC_OFS_CRC, 32'h0);
		wr(TCC_OFS_PRM, 32'h0);
		wr(TCC_OFS_CNT, 32'h1234);
		rd(TCC_OFS_CNT, 32'h0);
		apb(1'b1, 8'h20, 32'hff, q);
		check({31'h0, last_err}, 32'h1);
		rd(8'h20, 32'h0);
		check({31'h0, last_err}, 32'h1);
	endtask

	task automatic t_ff;
		wr(TCC_OFS_TOC, 32'h09);
		idle(3);
		check({31'h0, timer_output_pin}, 32'h1);
		rd(TCC_OFS_TOC, 32'h01);
		// Both requests together must leave the flip-flop alone
		wr(TCC_OFS_TOC, 32'h0d);
		idle(3);
		check({31'h0, timer_output_pin}, 32'h1);
		wr(TCC_OFS_TOC, 32'h05);
		idle(3);
		check({31'h0, timer_output_pin}, 32'h0);
		wr(TCC_OFS_TOC, 32'h08);
		idle(3);
		check({31'h0, timer_output_pin}, 32'h0);
	endtask

	task automatic t_toggle;
		int base;
		for (int c = 0; c < 3; c++)
		begin
			wr(TCC_OFS_TMC, 32'h0);
			wr(TCC_OFS_PRM, 32'(c));
			wr(TCC_OFS_CR0, 32'h3);
			wr(TCC_OFS_CR1, 32'h1);
			wr(TCC_OFS_TOC, 32'h13);
			wr(TCC_OFS_TMC, 32'h0c);
			idle(40);
			base = toggles;
			idle(64);
			check(32'(toggles - base), 32'(16 >> c));
		end
		wr(TCC_OFS_TOC, 32'h01);
		idle(8);
		base = toggles;
		idle(64);
		check(32'(toggles - base), 32'h0);
		wr(TCC_OFS_TMC, 32'h0);
		rd(TCC_OFS_CNT, 32'h0);
	endtask

	// Unarmed one-shot must stay quiet; one trigger gives exactly two toggles
	task automatic t_oneshot;
		int base;
		wr(TCC_OFS_PRM, 32'h0);
		wr(TCC_OFS_TOC, 32'h33);
		base = toggles;
		wr(TCC_OFS_TMC, 32'h04);
		idle(20);
		check(32'(toggles - base), 32'h0);
		wr(TCC_OFS_TOC, 32'h73);
		idle(20);
		check(32'(toggles - base), 32'h2);
		wr(TCC_OFS_TMC, 32'h0);
		wr(TCC_OFS_TOC, 32'h01);
	endtask

	// Pin already high at first enable after reset counts one edge; a restart does not
	task automatic t_first_edge;
		lvl0 <= 1'b1;
		presetn <= 1'b0;
		idle(3);
		presetn <= 1'b1;
		idle(1);
		rd(TCC_OFS_TOC, 32'h0);
		wr(TCC_OFS_PRM, 32'h13);
		wr(TCC_OFS_TMC, 32'h04);
		rd(TCC_OFS_CNT, 32'h1);
		wr(TCC_OFS_TMC, 32'h0);
		wr(TCC_OFS_TMC, 32'h04);
		idle(4);
		rd(TCC_OFS_CNT, 32'h0);
	endtask

	task automatic t_capture;
		wr(TCC_OFS_CR0, 32'h0);
		wr(TCC_OFS_CR1, 32'h0);
		wr(TCC_OFS_PRM, 32'h50);
		wr(TCC_OFS_CRC, 32'h01);
		wr(TCC_OFS_TMC, 32'h04);
		idle(20);
		lvl0 <= 1'b1;
		idle(5);
		rd(TCC_OFS_CR0, 32'h0);
		lvl1 <= 1'b1;
		idle(5);
		nz(TCC_OFS_CR0);
		wr(TCC_OFS_TMC, 32'h0);
		wr(TCC_OFS_CR0, 32'h0);
		wr(TCC_OFS_CRC, 32'h03);
		wr(TCC_OFS_TMC, 32'h04);
		idle(20);
		lvl1 <= 1'b0;
		idle(5);
		rd(TCC_OFS_CR0, 32'h0);
		lvl0 <= 1'b0;
		idle(5);
		nz(TCC_OFS_CR0);
		wr(TCC_OFS_TMC, 32'h0);
		wr(TCC_OFS_CRC, 32'h04);
		wr(TCC_OFS_TMC, 32'h04);
		idle(20);
		rd(TCC_OFS_CR1, 32'h0);
		lvl0 <= 1'b1;
		idle(5);
		nz(TCC_OFS_CR1);
	endtask

	initial
	begin
		presetn <= 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset_vals;
		t_regs;
		t_ff;
		t_toggle;
		t_oneshot;
		t_capture;
		t_first_edge;
		end_of_test;
	end
endmodule

bind tcc_top tcc_top_sva #(.INST(INST)) u_sva (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .timer_input0, .timer_input1,
	.timer_output_pin);
